// File: pcg_gate.sv
// Clock generator package and glitch-free gated copy of the halved clock
`timescale 1ns/10ps

package pcg_pkg;
    typedef enum logic [2:0] {
        PCG_ACTIVE = 3'b001,
        PCG_IDLE = 3'b010,
        PCG_PDOWN = 3'b100
    } pcg_mode_t;
    localparam pcg_mode_t PCG_MODE_RST = PCG_ACTIVE;
    localparam logic PCG_CLK_RST = 1'b0;
    localparam logic PCG_EN_RST = 1'b1;
    localparam logic PCG_SYNC_RST = 1'b0;
    localparam logic PCG_BYPASS_RST = 1'b0;
    localparam logic PCG_OSC_EN_RST = 1'b0;
    localparam logic PCG_STRAP_TAKEN_RST = 1'b0;
    localparam int PCG_SYNC_STAGES = 2;
endpackage : pcg_pkg

module pcg_gate
(
    input wire logic mclk,
    input wire logic resetn,
    input wire logic ce,
    input wire logic src_d,
    input wire logic run,
    output logic clk_q
);
    logic en_q;
    wire en_d;

    // Enable only changes while the source goes low, so no runt pulse
    assign en_d = src_d ? en_q : run;

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            en_q <= pcg_pkg::PCG_EN_RST;
            clk_q <= pcg_pkg::PCG_CLK_RST;
        end
        else if (ce)
        begin
            en_q <= en_d;
            clk_q <= src_d & en_d;
        end
    end
endmodule : pcg_gate

// File: pcg_top.sv
// Processor clock generator: halving divider, clock outputs, idle and powerdown
`timescale 1ns/10ps

module pcg_top
(
    input wire logic mclk,
    input wire logic resetn,
    input wire logic ce,
    input wire logic ext_clock_strap,
    input wire logic idle_req,
    input wire logic pdown_req,
    input wire logic wake_irq,
    output logic processor_clock_output,
    output logic cpu_clk,
    output logic periph_clk,
    output logic osc_enable,
    output pcg_pkg::pcg_mode_t mode
);
    pcg_pkg::pcg_mode_t mode_q;
    pcg_pkg::pcg_mode_t mode_d;
    logic half_q;
    logic osc_en_q;
    logic bypass_q;
    logic strap_taken_q;
    logic [pcg_pkg::PCG_SYNC_STAGES-1:0] wake_sync_q;

    wire half_d;
    wire osc_run;
    wire cpu_run;
    wire wake_seen;
    wire osc_en_d;

    // Interrupt pin is asynchronous to mclk
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            wake_sync_q <= {pcg_pkg::PCG_SYNC_STAGES{pcg_pkg::PCG_SYNC_RST}};
        end
        else if (ce)
        begin
            wake_sync_q <= {wake_sync_q[pcg_pkg::PCG_SYNC_STAGES-2:0], wake_irq};
        end
    end

    assign wake_seen = wake_sync_q[pcg_pkg::PCG_SYNC_STAGES-1];

    // Strap sampled once after reset release, never under the reset itself
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            strap_taken_q <= pcg_pkg::PCG_STRAP_TAKEN_RST;
            bypass_q <= pcg_pkg::PCG_BYPASS_RST;
        end
        else if (ce && !strap_taken_q)
        begin
            strap_taken_q <= 1'b1;
            bypass_q <= ext_clock_strap;
        end
    end

    // Power mode sequencing; powerdown request outranks idle
    always_comb
    begin
        mode_d = mode_q;
        case (mode_q)
            pcg_pkg::PCG_ACTIVE:
            begin
                if (pdown_req)
                begin
                    mode_d = pcg_pkg::PCG_PDOWN;
                end
                else if (idle_req)
                begin
                    mode_d = pcg_pkg::PCG_IDLE;
                end
            end
            pcg_pkg::PCG_IDLE:
            begin
                if (wake_seen)
                begin
                    mode_d = pcg_pkg::PCG_ACTIVE;
                end
                else if (pdown_req)
                begin
                    mode_d = pcg_pkg::PCG_PDOWN;
                end
            end
            pcg_pkg::PCG_PDOWN:
            begin
                if (wake_seen)
                begin
                    mode_d = pcg_pkg::PCG_ACTIVE;
                end
            end
            default:
            begin
                mode_d = pcg_pkg::PCG_ACTIVE;
            end
        endcase
    end

    assign osc_run = (mode_q != pcg_pkg::PCG_PDOWN);
    assign cpu_run = (mode_q == pcg_pkg::PCG_ACTIVE);
    // In powerdown a high half finishes its phase, then sits at zero
    assign half_d = osc_run & ~half_q;
    // Crystal amplifier unused when an external clock drives the input;
    // held off until the strap is known so an external source never sees it
    assign osc_en_d = osc_run & strap_taken_q & ~bypass_q;

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            mode_q <= pcg_pkg::PCG_MODE_RST;
            half_q <= pcg_pkg::PCG_CLK_RST;
            osc_en_q <= pcg_pkg::PCG_OSC_EN_RST;
        end
        else if (ce)
        begin
            mode_q <= mode_d;
            half_q <= half_d;
            osc_en_q <= osc_en_d;
        end
    end

    // Both gated clocks copy half_d so they stay in phase with the output
    pcg_gate u_cpu_gate
    (
        .mclk(mclk),
        .resetn(resetn),
        .ce(ce),
        .src_d(half_d),
        .run(cpu_run),
        .clk_q(cpu_clk)
    );

    pcg_gate u_periph_gate
    (
        .mclk(mclk),
        .resetn(resetn),
        .ce(ce),
        .src_d(half_d),
        .run(osc_run),
        .clk_q(periph_clk)
    );

    assign processor_clock_output = half_q;
    assign osc_enable = osc_en_q;
    assign mode = mode_q;

    wire st_idle;
    wire st_pdown;
    assign st_idle = (mode_q == pcg_pkg::PCG_IDLE);
    assign st_pdown = (mode_q == pcg_pkg::PCG_PDOWN);

    chk_half_rise: assert property (
        @(posedge mclk) disable iff (!resetn)
        (!st_pdown && ce && !half_q) |=> half_q)
        else $error("halved clock did not rise");

    chk_duty_equal: assert property (
        @(posedge mclk) disable iff (!resetn)
        (half_q && ce) |=> !half_q)
        else $error("clock output high phase too long");

    chk_cpu_source: assert property (
        @(posedge mclk) disable iff (!resetn)
        cpu_clk |-> processor_clock_output)
        else $error("cpu clock not derived from halved clock");

    chk_periph_source: assert property (
        @(posedge mclk) disable iff (!resetn)
        periph_clk |-> processor_clock_output)
        else $error("peripheral clock not derived from halved clock");

    chk_idle_cpu_low: assert property (
        @(posedge mclk) disable iff (!resetn)
        (st_idle && ce)[*3] |-> !cpu_clk)
        else $error("cpu clock runs in idle");

    chk_idle_periph_run: assert property (
        @(posedge mclk) disable iff (!resetn)
        (st_idle && ce)[*4] |-> (periph_clk != $past(periph_clk)))
        else $error("peripheral clock stopped in idle");

    chk_idle_stop_zero: assert property (
        @(posedge mclk) disable iff (!resetn)
        $rose(st_idle) |-> ##[0:2] !cpu_clk)
        else $error("cpu clock not held low after idle entry");

    chk_pdown_frozen: assert property (
        @(posedge mclk) disable iff (!resetn)
        (st_pdown && ce)[*3] |-> (!periph_clk && !cpu_clk && !processor_clock_output))
        else $error("clock running in powerdown");

    chk_pdown_osc_off: assert property (
        @(posedge mclk) disable iff (!resetn)
        (st_pdown && ce)[*2] |-> !osc_enable)
        else $error("oscillator enabled in powerdown");

    chk_bypass_osc_off: assert property (
        @(posedge mclk) disable iff (!resetn)
        bypass_q |-> !osc_enable)
        else $error("oscillator enabled with external clock");

    chk_wake_active: assert property (
        @(posedge mclk) disable iff (!resetn)
        ((st_idle || st_pdown) && wake_seen && ce) |=> (mode_q == pcg_pkg::PCG_ACTIVE))
        else $error("interrupt did not wake to active");

    cov_idle_wake: cover property (
        @(posedge mclk) disable iff (!resetn)
        st_idle ##[1:50] (mode_q == pcg_pkg::PCG_ACTIVE));

    cov_pdown_wake: cover property (
        @(posedge mclk) disable iff (!resetn)
        st_pdown ##[1:50] (mode_q == pcg_pkg::PCG_ACTIVE));

    cov_idle_to_pdown: cover property (
        @(posedge mclk) disable iff (!resetn)
        st_idle ##1 st_pdown);
endmodule : pcg_top

// File: pcg_xtal_model.sv
// Crystal network or external clock source feeding the generator
`timescale 1ns/10ps

module pcg_xtal_model
(
    input wire logic use_ext,
    output logic mclk,
    output logic ext_clock_strap
);
    assign ext_clock_strap = use_ext;
    // Keeps running in powerdown so the wake path still sees edges
    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
endmodule : pcg_xtal_model

// File: processor_clock_generator_tb.sv
// Self-checking bench for the processor clock generator
`timescale 1ns/10ps

module processor_clock_generator_tb;
    logic mclk, resetn, ce, strap, use_ext, idle_req, pdown_req, wake_irq;
    logic pco, cpu_clk, periph_clk, osc_enable, prev;
    pcg_pkg::pcg_mode_t mode;
    int fails = 0;
    int total_checks = 0;

    pcg_xtal_model src (.use_ext(use_ext), .mclk(mclk), .ext_clock_strap(strap));
    pcg_top uut (.mclk(mclk), .resetn(resetn), .ce(ce), .ext_clock_strap(strap),
        .idle_req(idle_req), .pdown_req(pdown_req), .wake_irq(wake_irq),
        .processor_clock_output(pco), .cpu_clk(cpu_clk), .periph_clk(periph_clk),
        .osc_enable(osc_enable), .mode(mode));

    task automatic conclude;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : conclude

    task automatic check(input logic [2:0] seen, input logic [2:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("CHECK FAILED at %0t: got %b want %b", $time, seen, exp);
        end
    endtask : check

    task automatic do_reset(input logic ext);
        @(posedge mclk);
        resetn <= 1'b0;
        use_ext <= ext;
        repeat (2) @(posedge mclk);
        @(negedge mclk);
        check({pco, cpu_clk, periph_clk}, 3'h0);
        check(mode, pcg_pkg::PCG_ACTIVE);
        @(posedge mclk);
        resetn <= 1'b1;
        repeat (3) @(posedge mclk);
        @(negedge mclk);
        check(osc_enable, !ext);
    endtask : do_reset

    task automatic wait_mode(input pcg_pkg::pcg_mode_t m);
        @(negedge mclk);
        for (int i = 0; i < 8 && mode !== m; i++)
            @(negedge mclk);
        check(mode, m);
        if (mode !== m)
            conclude();
    endtask : wait_mode

    task automatic run_active;
        @(negedge mclk);
        for (int i = 0; i < 8; i++)
        begin
            prev = pco;
            @(negedge mclk);
            check(pco, !prev);
            check({cpu_clk, periph_clk}, {pco, pco});
        end
    endtask : run_active

    task automatic wake;
        @(posedge mclk);
        wake_irq <= 1'b1;
        wait_mode(pcg_pkg::PCG_ACTIVE);
        @(posedge mclk);
        wake_irq <= 1'b0;
    endtask : wake

    task automatic pulse(input logic i, input logic p);
        @(posedge mclk);
        idle_req <= i;
        pdown_req <= p;
        @(posedge mclk);
        idle_req <= 1'b0;
        pdown_req <= 1'b0;
        @(negedge mclk);
    endtask : pulse

    task automatic idle_test;
        pulse(1'b1, 1'b0);
        check(mode, pcg_pkg::PCG_IDLE);
        repeat (2) @(negedge mclk);
        for (int i = 0; i < 6; i++)
        begin
            check(cpu_clk, 1'b0);
            check(periph_clk, pco);
            @(negedge mclk);
        end
        wake();
        repeat (3) @(negedge mclk);
        run_active();
    endtask : idle_test

    task automatic pdown_test;
        // Both asserted: powerdown must outrank idle
        pulse(1'b1, 1'b1);
        check(mode, pcg_pkg::PCG_PDOWN);
        repeat (2) @(negedge mclk);
        for (int i = 0; i < 6; i++)
        begin
            check({pco, cpu_clk, periph_clk}, 3'h0);
            check(osc_enable, 1'b0);
            @(negedge mclk);
        end
        pulse(1'b1, 1'b0);
        check(mode, pcg_pkg::PCG_PDOWN);
        wake();
        repeat (3) @(negedge mclk);
        run_active();
    endtask : pdown_test

    task automatic idle_pdown_test;
        pulse(1'b1, 1'b0);
        check(mode, pcg_pkg::PCG_IDLE);
        pulse(1'b0, 1'b1);
        check(mode, pcg_pkg::PCG_PDOWN);
        repeat (2) @(negedge mclk);
        check({pco, cpu_clk, periph_clk}, 3'h0);
        wake();
        repeat (3) @(negedge mclk);
        run_active();
    endtask : idle_pdown_test

    // Low clock enable must freeze the clocks and ignore requests
    task automatic freeze_test;
        logic [2:0] held;
        @(posedge mclk);
        ce <= 1'b0;
        idle_req <= 1'b1;
        @(negedge mclk);
        held = {pco, cpu_clk, periph_clk};
        for (int i = 0; i < 4; i++)
        begin
            @(negedge mclk);
            check({pco, cpu_clk, periph_clk}, held);
            check(mode, pcg_pkg::PCG_ACTIVE);
        end
        @(posedge mclk);
        ce <= 1'b1;
        idle_req <= 1'b0;
        run_active();
        check(mode, pcg_pkg::PCG_ACTIVE);
    endtask : freeze_test

    initial
    begin
        resetn = 1'b0;
        ce = 1'b1;
        use_ext = 1'b0;
        idle_req = 1'b0;
        pdown_req = 1'b0;
        wake_irq = 1'b0;
        do_reset(1'b0);
        run_active();
        idle_test();
        pdown_test();
        idle_pdown_test();
        freeze_test();
        pulse(1'b1, 1'b0);
        do_reset(1'b1);
        run_active();
        conclude();
    end

    initial
    begin
        #100000;
        fails++;
        conclude();
    end
endmodule : processor_clock_generator_tb
